// ==== common/pamx_pkg.sv ====
// Purpose: Shared constants and types for the port A pin function mux.
// Assumes: Avalon-MM slave with 32-bit data and byte addresses.
// Notes: Offsets are byte addresses; each register fills one aligned word.
package pamx_pkg;

  // Register offsets (byte addresses).
  localparam logic [7:0] PAMX_OFS_FUNC = 8'h30;
  localparam logic [7:0] PAMX_OFS_ALT  = 8'h34;

  // Reset values.
  localparam logic [31:0] PAMX_FUNC_RST = 32'h0000_0000;
  localparam logic [31:0] PAMX_ALT_RST  = 32'h0000_0000;

  // Field positions in the function register.
  localparam int PAMX_SCHMITT_LSB = 16;
  localparam int PAMX_SEL_P15     = 15;
  localparam int PAMX_SEL_P14     = 14;
  localparam int PAMX_SEL_P13     = 13;

  // Field positions in the alternate function register.
  localparam int PAMX_ALT_AMCLK   = 9;
  localparam int PAMX_ALT_EXT_EN  = 11;
  localparam int PAMX_ALT_HB6     = 22;
  localparam int PAMX_ALT_HB7     = 23;

  // Read data for an unmapped address.
  localparam logic [31:0] PAMX_UNMAPPED = 32'h0000_0000;

  // Function chosen for one pin.
  typedef enum logic [1:0] {
    PAMX_FN_GPIO   = 2'b00,
    PAMX_FN_PWM    = 2'b01,
    PAMX_FN_AMCLK  = 2'b10,
    PAMX_FN_EXTBUS = 2'b11
  } pamx_fn_t;

  // Avalon-MM request carried as one bundle.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } pamx_req_t;

endpackage : pamx_pkg

// ==== verilog/pamx_word_reg.sv ====
// Purpose: One 32-bit software register with byte-lane writes.
// Assumes: Write strobe is qualified by address decode upstream.
// Notes: Read data is the stored word itself, a flip-flop output.
`timescale 1ns/1ps
`default_nettype none
module pamx_word_reg
  import pamx_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Write side.
  input  wire logic        i_we,
  input  wire logic [3:0]  i_be,
  input  wire logic [31:0] i_wdata,
  // Stored word.
  output logic      [31:0] o_q
);

  logic [31:0] next_q;

  // Merge enabled byte lanes into the held word.
  always_comb begin
    next_q = o_q;
    for (int b = 0; b < 4; b++) begin
      if (i_we && i_be[b]) begin
        next_q[b*8 +: 8] = i_wdata[b*8 +: 8];
      end
    end
  end

  // Storage, cleared to its reset word.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= RST_VAL;
    end else begin
      o_q <= next_q;
    end
  end

endmodule // pamx_word_reg
`default_nettype wire

// ==== verilog/pamx_port_a_mux.sv ====
// Purpose: Port A pin function select and Schmitt input enable.
// Assumes: One clock; Avalon-MM slave answers with one wait cycle.
// Notes: Pins 12..0 keep their raw select bits as outputs only.
//
// Register map, byte addresses on the slave port:
//   0x30  function and input type word.
//         Bits 31..16 enable the Schmitt input of pins 15..0.
//         Bits 15..0 are the per-pin function select bits.
//   0x34  alternate function word, all 32 bits read and write.
//         Bit 9 steers pin 15 to the audio master clock.
//         Bit 11 enables the external bus.
//         Bits 23..16 are the external bus high byte enables.
//   Any other address reads as zero and ignores writes.
//
// Bus timing, as seen by a master:
//   Every request spends exactly one cycle with waitrequest high.
//   In the next cycle waitrequest is low; the write lands and the
//   read data stands at the rising edge that ends that cycle.
//   A request held on past its acknowledge starts a new wait cycle,
//   so a master that is slow to drop its strobe repeats the access.
//   Byte enables pick the lanes written; none set writes nothing.
//
// Pin function codes on o_pin15_fn, o_pin14_fn and o_pin13_fn:
//   0 general-purpose I/O, 1 PWM output, 2 audio master clock,
//   3 external bus address/data line.
//   The codes are registered, so they follow a register write by
//   one clock edge.  Software that switches a pin must allow for it.
//
// Hazards and intent:
//   A mixture of select and alternate bits that no table lists is
//   decoded as general-purpose I/O.  This keeps two functions from
//   ever driving the same pin while software updates the two words
//   one after the other.
//   Pins 14 and 13 share one decode function, so a fix to the
//   external bus rule reaches both pins at once.
//   The alternate bits are also brought out raw, because pins below
//   13 decode them outside this block.
//
// Function
// - Upper sixteen bits enable each pin's Schmitt input.
// - Pin 15: GPIO, PWM3, or audio master clock.
// - Pin 14: GPIO, PWM2, or external bus bit 15.
// - Pin 13: GPIO, PWM1, or external bus bit 14.
// - Function register resets to all zeros.
// - Pin 13 all three set gives bus bit 14.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pamx_port_a_mux
  import pamx_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Avalon-MM slave.
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Pin controls.
  output logic      [15:0] o_port_a_schmitt_enable,
  output logic      [15:0] o_port_a_function_select,
  output pamx_fn_t         o_pin15_fn,
  output pamx_fn_t         o_pin14_fn,
  output pamx_fn_t         o_pin13_fn,
  // Alternate bits seen by other pins.
  output logic             o_ext_bus_enable,
  output logic      [7:0]  o_ext_bus_high_byte_enable,
  output logic             o_pin15_audio_master_clock_select
);

  // Bus phase: a wait cycle first, then one acknowledge cycle.
  typedef enum logic {
    PAMX_BUS_WAIT = 1'h0,
    PAMX_BUS_ACK  = 1'h1
  } pamx_bus_st_t;

  pamx_req_t    req;
  logic         ack;
  logic         bus_req;
  pamx_bus_st_t bus_st;
  pamx_bus_st_t next_bus_st;
  logic         p15_amclk_w;
  logic         p15_pwm_w;
  logic [31:0] func_q;
  logic [31:0] alt_q;
  logic        sel_func;
  logic        sel_alt;
  logic        func_we;
  logic        alt_we;
  logic [31:0] rd_mux;
  logic        p15_sel;
  logic        p14_sel;
  logic        p13_sel;
  logic        amclk;
  logic        ext_en;
  logic        hb6;
  logic        hb7;
  pamx_fn_t    next_fn15;
  pamx_fn_t    next_fn14;
  pamx_fn_t    next_fn13;

  // Decode a pin with a plain PWM path and an external bus path.
  function automatic pamx_fn_t pin_fn_ebus(input logic sel,
                                           input logic en,
                                           input logic hb);
    pamx_fn_t f;
    f = PAMX_FN_GPIO;
    if (sel && !en && !hb) begin
      f = PAMX_FN_PWM;
    end else if (sel && en && hb) begin
      f = PAMX_FN_EXTBUS;
    end
    return f;
  endfunction

  // Bundle the bus request.
  assign req = '{read: i_avs_read, write: i_avs_write,
                 address: i_avs_address, byteenable: i_avs_byteenable,
                 writedata: i_avs_writedata};

  // Address decode and write strobes, taken on the acknowledge cycle.
  assign sel_func = (req.address == PAMX_OFS_FUNC);
  assign sel_alt  = (req.address == PAMX_OFS_ALT);
  assign func_we  = req.write && ack && sel_func;
  assign alt_we   = req.write && ack && sel_alt;
  assign o_avs_waitrequest = (req.read || req.write) && !ack;

  // Read selection; unmapped words read as zero.
  assign rd_mux = sel_func ? func_q :
                  sel_alt  ? alt_q  : PAMX_UNMAPPED;

  // Any read or write counts as a live request.
  assign bus_req = req.read || req.write;

  // Next bus phase: a request in the wait phase earns an acknowledge.
  always_comb begin
    case (bus_st)
      PAMX_BUS_WAIT: begin
        next_bus_st = bus_req ? PAMX_BUS_ACK : PAMX_BUS_WAIT;
      end
      PAMX_BUS_ACK: begin
        next_bus_st = PAMX_BUS_WAIT;
      end
      default: begin
        next_bus_st = PAMX_BUS_WAIT;
      end
    endcase
  end

  // Bus phase register; reset parks it in the wait phase.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_st <= PAMX_BUS_WAIT;
    end else begin
      bus_st <= next_bus_st;
    end
  end

  // Acknowledge lasts exactly one cycle, so waits are never longer.
  assign ack = (bus_st == PAMX_BUS_ACK);

  // Read data registered while waitrequest is high.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (req.read && !ack) begin
      o_avs_readdata <= rd_mux;
    end
  end

  // Function and input type register.
  pamx_word_reg #(
    .RST_VAL (PAMX_FUNC_RST)
  ) u_func (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (func_we),
    .i_be    (req.byteenable),
    .i_wdata (req.writedata),
    .o_q     (func_q)
  );

  // Alternate function register.
  pamx_word_reg #(
    .RST_VAL (PAMX_ALT_RST)
  ) u_alt (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (alt_we),
    .i_be    (req.byteenable),
    .i_wdata (req.writedata),
    .o_q     (alt_q)
  );

  // Field extraction.
  assign p15_sel = func_q[PAMX_SEL_P15];
  assign p14_sel = func_q[PAMX_SEL_P14];
  assign p13_sel = func_q[PAMX_SEL_P13];
  assign amclk   = alt_q[PAMX_ALT_AMCLK];
  assign ext_en  = alt_q[PAMX_ALT_EXT_EN];
  assign hb6     = alt_q[PAMX_ALT_HB6];
  assign hb7     = alt_q[PAMX_ALT_HB7];

  // Pin 15 choices as named terms; the select bit gates both.
  assign p15_amclk_w = p15_sel && amclk;
  assign p15_pwm_w   = p15_sel && !amclk;

  // Pin 15: audio clock only with its select bit also set.
  assign next_fn15 = p15_amclk_w ? PAMX_FN_AMCLK :
                     p15_pwm_w   ? PAMX_FN_PWM   :
                                   PAMX_FN_GPIO;
  // Pins 14 and 13 share the external bus decode.
  assign next_fn14 = pin_fn_ebus(p14_sel, ext_en, hb7);
  assign next_fn13 = pin_fn_ebus(p13_sel, ext_en, hb6);

  // Registered pin controls so data outputs come from flip-flops.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin15_fn <= PAMX_FN_GPIO;
      o_pin14_fn <= PAMX_FN_GPIO;
      o_pin13_fn <= PAMX_FN_GPIO;
    end else begin
      o_pin15_fn <= next_fn15;
      o_pin14_fn <= next_fn14;
      o_pin13_fn <= next_fn13;
    end
  end

  // Schmitt enables and raw selects straight from the register.
  assign o_port_a_schmitt_enable =
    func_q[PAMX_SCHMITT_LSB +: 16];
  assign o_port_a_function_select          = func_q[15:0];
  assign o_ext_bus_enable                  = ext_en;
  assign o_ext_bus_high_byte_enable        = alt_q[23:16];
  assign o_pin15_audio_master_clock_select = amclk;

endmodule // pamx_port_a_mux
`default_nettype wire

// ==== sim/pamx_port_a_mux_chk.sv ====
// Purpose: Assertions on the port A pin function mux ports.
// Assumes: Bound to pamx_port_a_mux from the bench top file.
// Notes: Pin codes follow their select bits one edge later.
`timescale 1ns/1ps
`default_nettype none
module pamx_port_a_mux_chk
  import pamx_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  // Pin controls.
  input wire logic [15:0] o_port_a_schmitt_enable,
  input wire logic [15:0] o_port_a_function_select,
  input wire pamx_fn_t    o_pin15_fn,
  input wire pamx_fn_t    o_pin14_fn,
  input wire pamx_fn_t    o_pin13_fn,
  input wire logic        o_ext_bus_enable,
  input wire logic [7:0]  o_ext_bus_high_byte_enable,
  input wire logic        o_pin15_audio_master_clock_select
);
  // Expected codes from the present select and alternate bits.
  wire logic [15:0] sel = o_port_a_function_select;
  wire logic        en  = o_ext_bus_enable;
  wire logic [7:0]  hb  = o_ext_bus_high_byte_enable;
  wire pamx_fn_t    e15 = !sel[15] ? PAMX_FN_GPIO :
    o_pin15_audio_master_clock_select ? PAMX_FN_AMCLK : PAMX_FN_PWM;
  wire pamx_fn_t    e14 = !sel[14] ? PAMX_FN_GPIO : (en & hb[7]) ?
    PAMX_FN_EXTBUS : (en | hb[7]) ? PAMX_FN_GPIO : PAMX_FN_PWM;
  wire pamx_fn_t    e13 = !sel[13] ? PAMX_FN_GPIO : (en & hb[6]) ?
    PAMX_FN_EXTBUS : (en | hb[6]) ? PAMX_FN_GPIO : PAMX_FN_PWM;
  wire logic        req = i_avs_read | i_avs_write;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_pin15_code: assert property (o_pin15_fn == $past(e15))
    else $error("pin 15 code wrong");
  chk_pin14_code: assert property (o_pin14_fn == $past(e14))
    else $error("pin 14 code wrong");
  chk_pin13_code: assert property (o_pin13_fn == $past(e13))
    else $error("pin 13 code wrong");
  chk_reset_clear: assert property ($rose(i_rst_n) |->
    o_port_a_schmitt_enable == 16'h0000 && sel == 16'h0000)
    else $error("function register not clear after reset");
  chk_schmitt_hold: assert property ($changed(o_port_a_schmitt_enable)
    |-> $past(i_avs_write && !o_avs_waitrequest &&
    i_avs_address == PAMX_OFS_FUNC)) else $error("schmitt bits moved");
  chk_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("no wait cycle on new request");
  chk_wait_once: assert property (req && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("wait longer than one cycle");
endmodule // pamx_port_a_mux_chk
`default_nettype wire

// ==== sim/pamx_port_a_mux_tb_top.sv ====
// Purpose: Self-checking bench for the port A pin function mux.
// Assumes: Bus answers after a wait cycle; the bench waits bounded.
// Notes: Pin codes are sampled two edges after each alternate word write.
`timescale 1ns/1ps
`default_nettype none
module pamx_port_a_mux_tb_top
  import pamx_pkg::*;
;
  logic        i_clk = 1'b0, i_rst_n = 1'b0;
  logic        i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [7:0]  i_avs_address = 8'h00;
  logic [3:0]  i_avs_byteenable = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata;
  logic        o_avs_waitrequest, o_ext_bus_enable;
  logic        o_pin15_audio_master_clock_select;
  logic [15:0] o_port_a_schmitt_enable, o_port_a_function_select;
  logic [7:0]  o_ext_bus_high_byte_enable;
  pamx_fn_t    o_pin15_fn, o_pin14_fn, o_pin13_fn;
  int          err_total = 0, tests_run = 0;

  pamx_port_a_mux pamx_port_a_mux_inst (.*);

  // Free-running 25 MHz clock.
  initial forever #20 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, wrong %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One bus cycle, held until waitrequest is seen low at an edge.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_byteenable <= b;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 50) begin
      err_total++;
      print_verdict();
    end
  endtask

  task automatic t_reset();
    logic [31:0] q;
    bus(1'b0, PAMX_OFS_FUNC, 4'hF, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    chk({o_port_a_schmitt_enable, o_port_a_function_select}, 32'h0);
    bus(1'b0, 8'h40, 4'hF, 32'h0000_0000, q);
    chk(q, PAMX_UNMAPPED);
    bus(1'b0, PAMX_OFS_ALT, 4'hF, 32'h0000_0000, q);
    chk(q, PAMX_ALT_RST);
    $display("reset test done");
  endtask

  task automatic t_schmitt();
    logic [31:0] q;
    bus(1'b1, PAMX_OFS_FUNC, 4'hC, 32'hA5C3_FFFF, q);
    bus(1'b0, PAMX_OFS_FUNC, 4'hF, 32'h0000_0000, q);
    chk(q, 32'hA5C3_0000);
    chk({16'h0000, o_port_a_schmitt_enable}, 32'h0000_A5C3);
    $display("schmitt test done");
  endtask

  // Every mix of select bits 15..13 together, audio clock, bus enable and high byte bits 7..6 together.
  task automatic t_pins();
    logic [31:0] q;
    logic [1:0]  e15, e14;
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, PAMX_OFS_FUNC, 4'hF, {16'h0, {3{k[0]}}, 13'h0}, q);
      bus(1'b1, PAMX_OFS_ALT, 4'hF, {8'h00, {2{k[3]}}, 10'h000, k[2],
          1'b0, k[1], 9'h000}, q);
      repeat (2) @(posedge i_clk);
      e15 = !k[0] ? 2'h0 : k[1] ? 2'h2 : 2'h1;
      e14 = !k[0] ? 2'h0 : (k[2] & k[3]) ? 2'h3 : (k[2] | k[3]) ? 2'h0 : 2'h1;
      chk({30'h0, o_pin15_fn}, {30'h0, e15});
      chk({30'h0, o_pin14_fn}, {30'h0, e14});
      chk({30'h0, o_pin13_fn}, {30'h0, e14});
      chk({16'h0, o_port_a_function_select}, {16'h0, {3{k[0]}}, 13'h0});
      chk({31'h0, o_pin15_audio_master_clock_select}, {31'h0, k[1]});
      chk({31'h0, o_ext_bus_enable}, {31'h0, k[2]});
      chk({24'h0, o_ext_bus_high_byte_enable}, {24'h0, {2{k[3]}}, 6'h0});
    end
    $display("pin function test done");
  endtask

  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_schmitt();
    t_pins();
    print_verdict();
  end
endmodule // pamx_port_a_mux_tb_top

bind pamx_port_a_mux pamx_port_a_mux_chk pamx_port_a_mux_chk_inst (.*);
`default_nettype wire
